// *** hdl/pdl_div.sv ***
/*
  divider, ratio reloaded only at terminal count.
  assumes one-cycle input pulses on clk.
*/
`timescale 1ns/100ps
module pdl_div
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_pulse, // one pulse per input edge
  input wire logic [17:0] ratio, // divide value, 0 and 1 both divide by one
  output logic out_pulse // one pulse per ratio input pulses
);
  import pdl_pkg::*;
  logic [17:0] cnt_r; // current count
  logic [17:0] ratio_r; // ratio in use

  // ==========================================================
  // counter, new ratio taken only at wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 18'h00000;
      ratio_r <= 18'h00001;
      out_pulse <= 1'b0;
    end
    else
    begin
      out_pulse <= 1'b0;
      if (in_pulse)
      begin
        if (cnt_r + 18'h00001 >= ratio_r) // boundary
        begin
          cnt_r <= 18'h00000;
          ratio_r <= ratio;
          out_pulse <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 18'h00001;
        end
      end
    end
  end
endmodule : pdl_div

// *** hdl/pdl_top.sv ***
/*
  divider setup, delay cells, digital lock detect, pin muxes.
  assumes slow reference and feedback pins, sampled on clk.
*/
`timescale 1ns/100ps
module pdl_top
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic ref_in, // reference clock pin
  input wire logic fb_in, // vco feedback pin
  input wire logic lock_pin_sense, // lock pin level seen by comparator
  output logic ref_div_out, // divided reference pulse to phase_detector
  output logic fb_div_out, // divided feedback pulse to phase_detector
  output logic [2:0] ref_delay_code, // r path delay cell code
  output logic ref_delay_en, // r path delay enable
  output logic [2:0] fb_delay_code, // n path delay code
  output logic fb_delay_en, // n path delay enable
  output logic digital_lock_flag, // lock state
  output logic lock_pin_o, // lock_pin data out
  output logic lock_pin_oe_n, // lock_pin enable, low drives
  output logic lock_pin_isrc, // current source on
  output logic status_pin, // status pin
  output logic reference_monitor_pin // monitor pin
);
  import pdl_pkg::*;

  // ==========================================================
  // reset release
  logic [1:0] rsync_r; // reset synchroniser
  logic rst_n; // synchronised reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rsync_r <= 2'b00;
    else
      rsync_r <= {rsync_r[0], 1'b1};
  end
  assign rst_n = rsync_r[1];

  // ==========================================================
  // registers
  logic [7:0] rlo_r, rhi_r, acnt_r, blo_r, bhi_r, presc_r;
  logic [7:0] stat_r, ldctl_r, dly_r, ldpin_r, mon_r, hold_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rlo_r <= PDL_RST_RLO;
      rhi_r <= PDL_RST_ZERO;
      acnt_r <= PDL_RST_ZERO;
      blo_r <= PDL_RST_BLO;
      bhi_r <= PDL_RST_ZERO;
      presc_r <= PDL_RST_PRESC;
      stat_r <= PDL_RST_ZERO;
      ldctl_r <= PDL_RST_ZERO;
      dly_r <= PDL_RST_ZERO;
      ldpin_r <= PDL_RST_ZERO;
      mon_r <= PDL_RST_ZERO;
      hold_r <= PDL_RST_ZERO;
    end
    else if (wr)
    begin
      unique case (addr)
        PDL_REG_RDIV_LO: rlo_r <= wdata;
        PDL_REG_RDIV_HI: rhi_r <= {2'b00, wdata[5:0]};
        PDL_REG_ACNT: acnt_r <= {2'b00, wdata[5:0]};
        PDL_REG_BCNT_LO: blo_r <= wdata;
        PDL_REG_BCNT_HI: bhi_r <= {3'b000, wdata[4:0]};
        PDL_REG_PRESC: presc_r <= {5'b00000, wdata[2:0]};
        PDL_REG_STAT_CTL: stat_r <= wdata;
        PDL_REG_LD_CTL: ldctl_r <= {1'b0, wdata[6:0]};
        PDL_REG_DELAY: dly_r <= wdata;
        PDL_REG_LDPIN: ldpin_r <= {2'b00, wdata[5:0]};
        PDL_REG_MON: mon_r <= wdata;
        PDL_REG_HOLD: hold_r <= wdata;
        default: ; // unmapped writes ignored
      endcase
    end
  end

  // ==========================================================
  // pin input synchronisers, three stages
  logic [2:0] ref_s_r, fb_s_r, ldp_s_r;
  logic ref_q_r, fb_q_r, ldp_q_r; // filtered levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_s_r <= 3'h0;
      fb_s_r <= 3'h0;
      ldp_s_r <= 3'h0;
      ref_q_r <= 1'b0;
      fb_q_r <= 1'b0;
      ldp_q_r <= 1'b0;
    end
    else
    begin
      ref_s_r <= {ref_s_r[1:0], ref_in};
      fb_s_r <= {fb_s_r[1:0], fb_in};
      ldp_s_r <= {ldp_s_r[1:0], lock_pin_sense};
      if (ref_s_r[1] == ref_s_r[2]) ref_q_r <= ref_s_r[2];
      if (fb_s_r[1] == fb_s_r[2]) fb_q_r <= fb_s_r[2];
      if (ldp_s_r[1] == ldp_s_r[2]) ldp_q_r <= ldp_s_r[2];
    end
  end
  logic ref_q_d_r, fb_q_d_r; // previous filtered levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_q_d_r <= 1'b0;
      fb_q_d_r <= 1'b0;
    end
    else
    begin
      ref_q_d_r <= ref_q_r;
      fb_q_d_r <= fb_q_r;
    end
  end

  // ==========================================================
  // divide ratios
  logic [17:0] r_ratio, n_ratio;
  logic [12:0] b_val;
  logic [5:0] a_val;
  logic [5:0] p_val;
  logic fd_mode;

  // prescaler ratio from mode code
  function automatic logic [5:0] presc_ratio(input logic [2:0] code);
    unique case (code)
      PDL_P_FD1: presc_ratio = 6'h01;
      PDL_P_DM2, PDL_P_FD2: presc_ratio = 6'h02;
      PDL_P_DM4: presc_ratio = 6'h04;
      PDL_P_DM8: presc_ratio = 6'h08;
      PDL_P_DM16: presc_ratio = 6'h10;
      PDL_P_DM32: presc_ratio = 6'h20;
      PDL_P_FD3: presc_ratio = 6'h03;
    endcase
  endfunction : presc_ratio

  always_comb
  begin
    r_ratio = {4'h0, rhi_r[5:0], rlo_r};
    b_val = {bhi_r[4:0], blo_r};
    a_val = acnt_r[5:0];
    p_val = presc_ratio(presc_r[2:0]);
    fd_mode = (presc_r[2:0] == PDL_P_FD1) || (presc_r[2:0] == PDL_P_FD2)
      || (presc_r[2:0] == PDL_P_FD3);
    if (p_val <= 6'h02 && b_val == 13'h0001)
      n_ratio = {12'h000, p_val};
    else if (fd_mode)
      n_ratio = {12'h000, p_val} * {5'h00, b_val};
    else
      n_ratio = {12'h000, p_val} * {5'h00, b_val} + {12'h000, a_val}; // host keeps a <= b
  end

  logic ref_edge, fb_edge;
  assign ref_edge = ref_q_r && !ref_q_d_r;
  assign fb_edge = fb_q_r && !fb_q_d_r;

  pdl_div u_rdiv
  (
    .clk(clk),
    .rst_n(rst_n),
    .in_pulse(ref_edge),
    .ratio(r_ratio),
    .out_pulse(ref_div_out)
  );
  pdl_div u_ndiv
  (
    .clk(clk),
    .rst_n(rst_n),
    .in_pulse(fb_edge),
    .ratio(n_ratio),
    .out_pulse(fb_div_out)
  );

  // ==========================================================
  // delay codes follow the reference divider boundary
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_delay_code <= 3'h0;
      ref_delay_en <= 1'b0;
      fb_delay_code <= 3'h0;
      fb_delay_en <= 1'b0;
    end
    else if (ref_div_out)
    begin
      ref_delay_en <= dly_r[PDL_RDLY_EN];
      ref_delay_code <= dly_r[PDL_RDLY_LSB +: 3];
      fb_delay_en <= dly_r[PDL_NDLY_EN];
      fb_delay_code <= dly_r[PDL_NDLY_LSB +: 3];
    end
  end

  // ==========================================================
  // edge time difference at the phase_detector
  typedef enum logic [1:0] {
    PDL_IDLE = 2'b00, // waiting for first edge
    PDL_REF_LEAD = 2'b01, // reference edge came first
    PDL_FB_LEAD = 2'b10 // feedback edge came first
  } pdl_meas_e;
  pdl_meas_e meas_r;
  logic [PDL_CYC_W-1:0] diff_r; // cycles since leading edge
  logic done_r; // one pulse per compared pair
  logic [PDL_CYC_W-1:0] res_r; // measured difference
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meas_r <= PDL_IDLE;
      diff_r <= '0;
      done_r <= 1'b0;
      res_r <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      if (diff_r != '1) diff_r <= diff_r + 1'b1;
      unique case (meas_r)
        PDL_IDLE:
        begin
          diff_r <= '0;
          if (ref_div_out && fb_div_out)
          begin
            done_r <= 1'b1; // aligned edges
            res_r <= '0;
          end
          else if (ref_div_out)
            meas_r <= PDL_REF_LEAD;
          else if (fb_div_out)
            meas_r <= PDL_FB_LEAD;
        end
        PDL_REF_LEAD, PDL_FB_LEAD:
        begin
          if ((meas_r == PDL_REF_LEAD && fb_div_out) ||
              (meas_r == PDL_FB_LEAD && ref_div_out))
          begin
            done_r <= 1'b1;
            res_r <= diff_r + 1'b1;
            meas_r <= PDL_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // lock detector
  logic [PDL_CYC_W-1:0] lock_thr, unlock_thr; // window widths in cycles
  logic [7:0] need_cnt; // consecutive good cycles required
  always_comb
  begin
    // antibacklash widens, range bit 0 doubles
    lock_thr = PDL_CYC_W'((PDL_LOCK_BASE + int'(stat_r[PDL_ABP_LSB +: 2]))
      * PDL_WIN_CYC * (ldctl_r[PDL_LDW_BIT] ? 1 : 2));
    unlock_thr = PDL_CYC_W'((PDL_UNLOCK_BASE + int'(stat_r[PDL_ABP_LSB +: 2]))
      * PDL_WIN_CYC * (ldctl_r[PDL_LDW_BIT] ? 1 : 2));
    unique case (ldctl_r[PDL_LDC_LSB +: 2])
      2'b00: need_cnt = 8'h05;
      2'b01: need_cnt = 8'h10;
      2'b10: need_cnt = 8'h40;
      2'b11: need_cnt = 8'hff;
    endcase
  end
  logic [7:0] good_r; // consecutive good cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_r <= 8'h00;
      digital_lock_flag <= 1'b0;
    end
    else if (ldctl_r[PDL_LDDIS_BIT])
    begin
      good_r <= 8'h00;
      digital_lock_flag <= 1'b0;
    end
    else if (done_r)
    begin
      if (digital_lock_flag)
      begin
        if (res_r > unlock_thr)
        begin
          digital_lock_flag <= 1'b0;
          good_r <= 8'h00;
        end
      end
      else if (res_r < lock_thr)
      begin
        if (good_r + 8'h01 >= need_cnt)
          digital_lock_flag <= 1'b1;
        else
          good_r <= good_r + 8'h01;
      end
      else
        good_r <= 8'h00;
    end
  end

  // ==========================================================
  // analog pulse while a phase error is measured
  logic ald_pulse;
  assign ald_pulse = (meas_r != PDL_IDLE);
  logic cmp; // comparator output, forced high when disabled
  assign cmp = hold_r[PDL_CMP_BIT] ? ldp_q_r : 1'b1;

  // status and monitor mux
  function automatic logic pin_sel(input logic [5:0] code, input logic lk, input logic c);
    if (code == PDL_PIN_LOCK) pin_sel = lk;
    else if (code == PDL_PIN_CMP_HI) pin_sel = c;
    else if (code == PDL_PIN_CMP_LO) pin_sel = !c;
    else pin_sel = 1'b0;
  endfunction : pin_sel

  // ==========================================================
  // pin outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_pin_o <= 1'b0;
      lock_pin_oe_n <= 1'b0;
      lock_pin_isrc <= 1'b0;
      status_pin <= 1'b0;
      reference_monitor_pin <= 1'b0;
    end
    else
    begin
      status_pin <= pin_sel(stat_r[PDL_STS_LSB +: 6], digital_lock_flag, cmp);
      reference_monitor_pin <= pin_sel({1'b0, mon_r[4:0]}, digital_lock_flag, cmp);
      lock_pin_isrc <= 1'b0;
      lock_pin_oe_n <= 1'b0;
      lock_pin_o <= 1'b0;
      unique case (ldpin_r[5:0])
        PDL_PIN_LOCK: lock_pin_o <= digital_lock_flag;
        PDL_PIN_ALD_N: lock_pin_oe_n <= !ald_pulse; // low pulses, else released
        PDL_PIN_ALD_P:
        begin
          lock_pin_o <= 1'b1; // high pulses, else released
          lock_pin_oe_n <= !ald_pulse;
        end
        PDL_PIN_CSRC:
        begin
          lock_pin_isrc <= digital_lock_flag;
          lock_pin_oe_n <= digital_lock_flag; // grounds at once when false
        end
        default: lock_pin_o <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        PDL_REG_RDIV_LO: rdata <= rlo_r;
        PDL_REG_RDIV_HI: rdata <= rhi_r;
        PDL_REG_ACNT: rdata <= acnt_r;
        PDL_REG_BCNT_LO: rdata <= blo_r;
        PDL_REG_BCNT_HI: rdata <= bhi_r;
        PDL_REG_PRESC: rdata <= presc_r;
        PDL_REG_STAT_CTL: rdata <= stat_r;
        PDL_REG_LD_CTL: rdata <= ldctl_r;
        PDL_REG_DELAY: rdata <= dly_r;
        PDL_REG_LDPIN: rdata <= ldpin_r;
        PDL_REG_MON: rdata <= mon_r;
        PDL_REG_HOLD: rdata <= hold_r;
        PDL_REG_STATUS: rdata <= {5'h00, cmp, ald_pulse, digital_lock_flag};
        default: rdata <= 8'h00; // unmapped reads zero
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule : pdl_top

// *** shared/pdl_pkg.sv ***
/*
  constants of the divider and lock-detect block.
  assumes one 40 mhz clock and a plain register port.
*/
// How it works
// - two enabled 3-bit delay cells, r and n
// - p of 1 or 2 with b=1 bypasses counters
// - fixed divide ignores swallow count: n=p*b
// - lock below lock window, unlock beyond wider window
// - lock after programmed consecutive good cycles
// - one bad cycle past unlock window drops lock
// - window from range bit and antibacklash
// - lock flag selectable on three output pins
// - current-source mode sources while locked, else grounds
// - any false lock discharges pin at once
// - pin comparator on monitor and status, both polarities
// - open-drain n and p analog lock pulse variants
// - counter code 00 means five cycles
// - lock detector runs only when disable bit clear
// - pin code 000100 selects current-source mode
package pdl_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] PDL_REG_RDIV_LO = 8'h11; // r divider low byte
  localparam logic [7:0] PDL_REG_RDIV_HI = 8'h12; // r divider high bits
  localparam logic [7:0] PDL_REG_ACNT = 8'h13;    // swallow count
  localparam logic [7:0] PDL_REG_BCNT_LO = 8'h14; // main count low
  localparam logic [7:0] PDL_REG_BCNT_HI = 8'h15; // main count high
  localparam logic [7:0] PDL_REG_PRESC = 8'h16;   // prescaler mode
  localparam logic [7:0] PDL_REG_STAT_CTL = 8'h17; // status mux and antibacklash
  localparam logic [7:0] PDL_REG_LD_CTL = 8'h18;  // lock counter, range, disable
  localparam logic [7:0] PDL_REG_DELAY = 8'h19;   // delay cells
  localparam logic [7:0] PDL_REG_LDPIN = 8'h1a;   // lock pin mux
  localparam logic [7:0] PDL_REG_MON = 8'h1b;     // monitor pin mux
  localparam logic [7:0] PDL_REG_HOLD = 8'h1d;    // comparator enable
  localparam logic [7:0] PDL_REG_STATUS = 8'h1f;  // read-only status
  // ==========================================================
  // field positions
  localparam int PDL_LDC_LSB = 5;   // lock counter [6:5]
  localparam int PDL_LDW_BIT = 4;   // window range
  localparam int PDL_LDDIS_BIT = 3; // disable lock detect
  localparam int PDL_ABP_LSB = 0;   // antibacklash [1:0]
  localparam int PDL_STS_LSB = 2;   // status mux [7:2]
  localparam int PDL_RDLY_EN = 6;   // r delay enable
  localparam int PDL_RDLY_LSB = 3;  // r delay code [5:3]
  localparam int PDL_NDLY_EN = 7;   // n delay enable (own)
  localparam int PDL_NDLY_LSB = 0;  // n delay code [2:0]
  localparam int PDL_CMP_BIT = 3;   // comparator enable
  // ==========================================================
  // reset values
  localparam logic [7:0] PDL_RST_ZERO = 8'h00;
  localparam logic [7:0] PDL_RST_RLO = 8'h01;
  localparam logic [7:0] PDL_RST_BLO = 8'h03;
  localparam logic [7:0] PDL_RST_PRESC = 8'h06;
  // ==========================================================
  // prescaler modes
  localparam logic [2:0] PDL_P_FD1 = 3'h0; // fixed_divide_setting 1 (own code map)
  localparam logic [2:0] PDL_P_DM2 = 3'h1; // dual_modulus_setting 2/3
  localparam logic [2:0] PDL_P_DM4 = 3'h2;
  localparam logic [2:0] PDL_P_DM8 = 3'h3;
  localparam logic [2:0] PDL_P_DM16 = 3'h4;
  localparam logic [2:0] PDL_P_DM32 = 3'h5;
  localparam logic [2:0] PDL_P_FD2 = 3'h6;
  localparam logic [2:0] PDL_P_FD3 = 3'h7;
  // ==========================================================
  // pin mux codes
  localparam logic [5:0] PDL_PIN_LOCK = 6'h00;     // digital_lock_flag
  localparam logic [5:0] PDL_PIN_ALD_N = 6'h01;    // n-channel analog_lock_pulse
  localparam logic [5:0] PDL_PIN_ALD_P = 6'h02;    // p-channel analog_lock_pulse
  localparam logic [5:0] PDL_PIN_CSRC = 6'h04;     // current-source lock mode
  localparam logic [5:0] PDL_PIN_CMP_HI = 6'h05;   // pin comparator, active high
  localparam logic [5:0] PDL_PIN_CMP_LO = 6'h06;   // pin comparator, active low
  localparam logic [5:0] PDL_PIN_LOW = 6'h3f;      // static low
  // ==========================================================
  // window timing, one unit per clk cycle
  localparam int PDL_CLK_MHZ = 40;
  localparam int PDL_WIN_NS = 25;
  localparam int PDL_WIN_CYC = (PDL_WIN_NS * PDL_CLK_MHZ + 999) / 1000; // rounds up
  localparam int PDL_LOCK_BASE = 1;   // lock window, units, high range
  localparam int PDL_UNLOCK_BASE = 3; // unlock window, units, high range
  localparam int PDL_CYC_W = 12;
endpackage : pdl_pkg

// *** testbench/pdl_src.sv ***
/*
  far side: reference, lagged feedback, lock pin capacitor.
  assumes period and lag in ns.
*/
`timescale 1ns/100ps
module pdl_src
(
  input wire logic clk,
  input wire logic run, // source produces edges
  input wire logic [15:0] half_ns, // half period of reference
  input wire logic [15:0] skew_ns, // feedback lag behind reference
  input wire logic lock_pin_o,
  input wire logic lock_pin_oe_n,
  input wire logic lock_pin_isrc,
  output logic ref_in,
  output logic fb_in,
  output logic lock_pin_sense
);
  logic [7:0] cap_r = 8'h00; // charge on the lock pin capacitor
  initial ref_in = 1'b0;
  initial fb_in = 1'b0;
  // reference square wave, stands low while stopped
  always
  begin
    if (run)
    begin
      ref_in = 1'b1;
      #(half_ns);
      ref_in = 1'b0;
      #(half_ns);
    end
    else
      #25;
  end
  // feedback follows the reference after the lag
  always @(ref_in) fb_in <= #(skew_ns) ref_in;
  // capacitor charges on the source, empties when grounded
  always @(posedge clk)
  begin
    if (!lock_pin_oe_n && !lock_pin_o) cap_r <= 8'h00;
    else if (lock_pin_isrc && cap_r != 8'hff) cap_r <= cap_r + 8'h01;
  end
  assign lock_pin_sense = (cap_r > 8'd20); // comparator trip point
endmodule : pdl_src

// *** testbench/pdl_top_sva.sv ***
/*
  checker for pdl_top: lock flag, lock pin, divider pulses.
  assumes pin periods of 8 clk cycles or more.
*/
`timescale 1ns/100ps
module pdl_top_sva
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr,
  input wire logic ref_div_out,
  input wire logic fb_div_out,
  input wire logic [2:0] ref_delay_code,
  input wire logic ref_delay_en,
  input wire logic [2:0] fb_delay_code,
  input wire logic fb_delay_en,
  input wire logic digital_lock_flag,
  input wire logic lock_pin_oe_n,
  input wire logic lock_pin_isrc
);
  logic [7:0] good_r; // feedback pulses seen while unlocked
  logic [3:0] quiet_r; // cycles since a divider pulse or a write
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // helper counters
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n) good_r <= 8'h00;
    else if (digital_lock_flag) good_r <= 8'h00;
    else if (fb_div_out && good_r != 8'hff) good_r <= good_r + 8'h01;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n) quiet_r <= 4'hf;
    else if (ref_div_out || fb_div_out || wr) quiet_r <= 4'h0;
    else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
  end
  // ==========================================================
  // assertions
  a_csrc_release: assert property (lock_pin_isrc |-> lock_pin_oe_n)
    else $error("current source on while pin is driven");
  a_csrc_drop: assert property ($fell(digital_lock_flag) |-> ##[0:2] !lock_pin_isrc)
    else $error("source on after lock loss");
  a_lock_count: assert property ($rose(digital_lock_flag) |-> good_r >= 8'd5)
    else $error("lock declared after too few cycles");
  a_lock_on_pair: assert property ($rose(digital_lock_flag) |-> quiet_r <= 4'd4)
    else $error("lock declared away from an edge pair");
  a_unlock_on_pair: assert property ($fell(digital_lock_flag) |-> quiet_r <= 4'd12)
    else $error("lock dropped away from an edge pair");
  a_ref_single: assert property (ref_div_out |=> !ref_div_out)
    else $error("ref pulse too wide");
  a_fb_single: assert property (fb_div_out |=> !fb_div_out)
    else $error("fb pulse too wide");
  a_delay_boundary: assert property (
    $changed({ref_delay_en, ref_delay_code, fb_delay_en, fb_delay_code})
    |-> $past(ref_div_out) or ##[0:1] ref_div_out)
    else $error("delay codes changed off boundary");
  // ==========================================================
  // covers
  c_lock: cover property ($rose(digital_lock_flag));
  c_unlock: cover property ($fell(digital_lock_flag));
  c_csrc: cover property (lock_pin_isrc);
endmodule : pdl_top_sva

bind pdl_top pdl_top_sva i_pdl_top_sva
(
  .clk(clk),
  .reset_n(reset_n),
  .wr(wr),
  .ref_div_out(ref_div_out),
  .fb_div_out(fb_div_out),
  .ref_delay_code(ref_delay_code),
  .ref_delay_en(ref_delay_en),
  .fb_delay_code(fb_delay_code),
  .fb_delay_en(fb_delay_en),
  .digital_lock_flag(digital_lock_flag),
  .lock_pin_oe_n(lock_pin_oe_n),
  .lock_pin_isrc(lock_pin_isrc)
);

// *** testbench/pdl_top_tb.sv ***
/*
  bench for pdl_top: registers, dividers, delays, lock, pins.
  assumes pdl_src and the bound checker.
*/
`timescale 1ns/100ps
module pdl_top_tb;
  import pdl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic [15:0] half_ns = 16'd200; // 16 clk period, above the unlock window
  logic [15:0] skew_ns = 16'd0;
  logic [7:0] rdata;
  logic ref_in, fb_in, lock_pin_sense, ref_div_out, fb_div_out;
  logic [2:0] ref_delay_code, fb_delay_code;
  logic ref_delay_en, fb_delay_en, digital_lock_flag;
  logic lock_pin_o, lock_pin_oe_n, lock_pin_isrc, status_pin, reference_monitor_pin;
  int bad_count = 0;
  int n_checks = 0;
  int nr, nf;
  always #12.5 clk = ~clk;
  pdl_top i_pdl_top (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ref_in(ref_in), .fb_in(fb_in), .lock_pin_sense(lock_pin_sense),
    .ref_div_out(ref_div_out), .fb_div_out(fb_div_out), .ref_delay_code(ref_delay_code),
    .ref_delay_en(ref_delay_en), .fb_delay_code(fb_delay_code), .fb_delay_en(fb_delay_en),
    .digital_lock_flag(digital_lock_flag), .lock_pin_o(lock_pin_o),
    .lock_pin_oe_n(lock_pin_oe_n), .lock_pin_isrc(lock_pin_isrc), .status_pin(status_pin),
    .reference_monitor_pin(reference_monitor_pin));
  pdl_src i_pdl_src (.clk(clk), .run(run), .half_ns(half_ns), .skew_ns(skew_ns),
    .lock_pin_o(lock_pin_o), .lock_pin_oe_n(lock_pin_oe_n), .lock_pin_isrc(lock_pin_isrc),
    .ref_in(ref_in), .fb_in(fb_in), .lock_pin_sense(lock_pin_sense));
  // ==========================================================
  // compare and bus tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, rdata);
  endtask : rd_chk
  // bounded wait for lock flag
  task automatic wait_lock(input logic exp, input int lim, output int pulses);
    pulses = 0;
    for (int i = 0; i < lim && digital_lock_flag !== exp; i++)
    begin
      @(posedge clk);
      #1;
      if (fb_div_out) pulses++;
    end
    chk("lock flag", {7'h00, exp}, {7'h00, digital_lock_flag});
  endtask : wait_lock
  task automatic hold_lock(input logic exp, input int cyc);
    logic held;
    held = 1'b1;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (digital_lock_flag !== exp) held = 1'b0;
    end
    chk("lock flag held", 8'h01, {7'h00, held});
  endtask : hold_lock
  task automatic count_pulses(input int cyc, output int r, output int f);
    r = 0;
    f = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (ref_div_out) r++;
      if (fb_div_out) f++;
    end
  endtask : count_pulses
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // watchdog
  initial
  begin
    #(25 * 20000);
    bad_count++;
    end_sim;
  end
  // ==========================================================
  // test sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(PDL_REG_RDIV_LO, PDL_RST_RLO);
    rd_chk(PDL_REG_BCNT_LO, PDL_RST_BLO);
    rd_chk(PDL_REG_PRESC, PDL_RST_PRESC);
    rd_chk(PDL_REG_LD_CTL, PDL_RST_ZERO);
    rd_chk(8'h00, 8'h00);
    $display("test reset values done");
    wr_reg(PDL_REG_DELAY, 8'hda);
    repeat (10) @(posedge clk);
    chk("delay held", 8'h00, {5'h00, ref_delay_code});
    run <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk("r delay", 8'h0b, {4'h0, ref_delay_en, ref_delay_code});
    chk("n delay", 8'h0a, {4'h0, fb_delay_en, fb_delay_code});
    $display("test delay cells done");
    wr_reg(PDL_REG_RDIV_LO, 8'h02);
    wr_reg(PDL_REG_ACNT, 8'h05);
    repeat (64) @(posedge clk);
    count_pulses(768, nr, nf);
    chk("r pulses", 8'h01, {7'h00, (nr >= 23 && nr <= 25)});
    chk("n pulses", 8'h01, {7'h00, (nf >= 7 && nf <= 9)});
    wr_reg(PDL_REG_LD_CTL, 8'h18);
    wr_reg(PDL_REG_RDIV_LO, 8'h01);
    wr_reg(PDL_REG_ACNT, 8'h00);
    wr_reg(PDL_REG_PRESC, {5'h00, PDL_P_FD1});
    wr_reg(PDL_REG_BCNT_LO, 8'h01);
    repeat (64) @(posedge clk);
    count_pulses(320, nr, nf);
    chk("bypass pulses", 8'h01, {7'h00, (nf >= 19 && nf <= 21)});
    $display("test dividers done");
    wr_reg(PDL_REG_LD_CTL, 8'h10);
    wait_lock(1'b1, 2000, nf);
    chk("pairs to lock", 8'h01, {7'h00, (nf >= 5 && nf <= 7)});
    skew_ns <= 16'd50;
    hold_lock(1'b1, 160);
    skew_ns <= 16'd200;
    wait_lock(1'b0, 48, nf);
    skew_ns <= 16'd50;
    hold_lock(1'b0, 160);
    wr_reg(PDL_REG_STAT_CTL, 8'h02);
    wait_lock(1'b1, 400, nf);
    wr_reg(PDL_REG_LD_CTL, 8'h00);
    skew_ns <= 16'd200;
    hold_lock(1'b1, 160);
    wr_reg(PDL_REG_LD_CTL, 8'h10);
    wait_lock(1'b0, 48, nf);
    $display("test lock windows done");
    skew_ns <= 16'd0;
    wait_lock(1'b1, 400, nf);
    wr_reg(PDL_REG_LD_CTL, 8'h18);
    wait_lock(1'b0, 8, nf);
    hold_lock(1'b0, 64);
    wr_reg(PDL_REG_LD_CTL, 8'h10);
    wait_lock(1'b1, 400, nf);
    $display("test disable done");
    wr_reg(PDL_REG_STAT_CTL, 8'h00);
    wr_reg(PDL_REG_MON, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk("lock pins", 8'h07, {5'h00, lock_pin_o, status_pin, reference_monitor_pin});
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(PDL_REG_LDPIN, {2'b00, (k == 0) ? PDL_PIN_ALD_N : PDL_PIN_ALD_P});
      repeat (8) @(posedge clk);
      #1;
      chk("analog pin idle", 8'h01, {7'h00, lock_pin_oe_n});
    end
    wr_reg(PDL_REG_LDPIN, {2'b00, PDL_PIN_CSRC});
    wr_reg(PDL_REG_HOLD, 8'h08);
    wr_reg(PDL_REG_STAT_CTL, {PDL_PIN_CMP_HI, 2'b00});
    wr_reg(PDL_REG_MON, {3'h0, PDL_PIN_CMP_LO[4:0]});
    repeat (40) @(posedge clk);
    #1;
    chk("source on", 8'h03, {6'h00, lock_pin_isrc, lock_pin_oe_n});
    chk("comparator", 8'h02, {6'h00, status_pin, reference_monitor_pin});
    skew_ns <= 16'd200;
    wait_lock(1'b0, 48, nf);
    repeat (3) @(posedge clk);
    #1;
    chk("pin grounded", 8'h00, {5'h00, lock_pin_isrc, lock_pin_oe_n, lock_pin_o});
    repeat (8) @(posedge clk);
    #1;
    chk("comparator low", 8'h01, {6'h00, status_pin, reference_monitor_pin});
    $display("test lock pins done");
    end_sim;
  end
endmodule : pdl_top_tb
